/* logic/uart_alt_function_control.sv */
// serial port personality and alternate mode control with ahb-lite registers
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
module uart_alt_function_control
(
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // bit-time strobe from the baud generator, same clock
  input wire logic bit_tick,
  // line personality
  output alt_func_pkg::personality_t port_personality,
  // rs-485 controls
  output logic [7:0] rs485_addr_match,
  output logic rs485_addr_detect_on,
  output logic rs485_auto_direction,
  output logic rs485_auto_addr_detect,
  output logic rs485_normal_multidrop,
  // lin controls
  output logic lin_rx_enable,
  output logic lin_break_active,
  // irda controls
  output logic irda_tx_enable,
  output logic irda_rx_enable
);
  import alt_func_pkg::*;

  // -------------------------------------------------------------------
  // bus address phase capture
  // -------------------------------------------------------------------
  logic dph_write_r;
  logic [7:0] dph_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] alt_r;
  logic [31:0] fsel_r;
  logic [31:0] irda_r;

  // -------------------------------------------------------------------
  // register decode, shared by the write strobes and the read mux
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {sel_none, sel_irda, sel_alt, sel_fsel} reg_sel_t;

  function automatic reg_sel_t decode_reg(input logic [7:0] addr);
    case (addr)
      irda_control_off: decode_reg = sel_irda;
      alternate_mode_control_off: decode_reg = sel_alt;
      function_select_off: decode_reg = sel_fsel;
      default: decode_reg = sel_none;
    endcase
  endfunction

  // hsize unused: only whole-word transfers are issued
  wire addr_valid = hsel && htrans[1] && hready;
  wire reg_sel_t wr_sel = decode_reg(dph_addr_r);
  wire reg_sel_t rd_sel = decode_reg(haddr);
  wire wr_alt = dph_write_r && (wr_sel == sel_alt);
  wire wr_fsel = dph_write_r && (wr_sel == sel_fsel);
  wire wr_irda = dph_write_r && (wr_sel == sel_irda);
  wire rd_take = addr_valid && !hwrite;

  // -------------------------------------------------------------------
  // personality gating
  // -------------------------------------------------------------------
  wire personality_t pers = personality_t'(fsel_r[1:0]);
  wire is_lin = (pers == pers_lin);
  wire is_irda = (pers == pers_irda);
  wire is_rs485 = (pers == pers_rs485);

  // -------------------------------------------------------------------
  // lin break request and self-clear
  // -------------------------------------------------------------------
  logic brk_busy;
  logic brk_done;
  wire brk_req = alt_r[lin_tx_bit];
  // break waits until lin is selected; a pending request stays visible
  wire brk_start = brk_req && is_lin && !brk_busy && !brk_done;
  // a written zero withdraws a request still waiting for lin
  // software set wins over the hardware clear in the same cycle
  wire brk_bit_nxt = wr_alt ? hwdata[lin_tx_bit] : (brk_done ? 1'b0 : brk_req);

  lin_break_timer u_break
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(brk_start),
    .bit_tick(bit_tick),
    .break_length(alt_r[break_len_lsb +: 4]),
    .busy(brk_busy),
    .done(brk_done)
  );

  // -------------------------------------------------------------------
  // register next values and read mux
  // -------------------------------------------------------------------
  wire [31:0] alt_sw = wr_alt ? (hwdata & alt_wr_mask) : alt_r;
  wire [31:0] alt_nxt = {alt_sw[31:lin_tx_bit + 1], brk_bit_nxt, alt_sw[lin_tx_bit - 1:0]};
  wire [31:0] fsel_nxt = wr_fsel ? (hwdata & fsel_wr_mask) : fsel_r;
  wire [31:0] irda_nxt = wr_irda ? (hwdata & irda_wr_mask) : irda_r;
  // reserved bits are held at zero by the write masks
  wire [31:0] rd_mux = (rd_sel == sel_alt) ? alt_nxt :
                       (rd_sel == sel_fsel) ? fsel_nxt :
                       (rd_sel == sel_irda) ? irda_nxt : 32'h0000_0000;
  wire [31:0] rdata_nxt = rd_take ? rd_mux : rdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_write_r <= 1'b0;
      dph_addr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      dph_write_r <= addr_valid && hwrite;
      dph_addr_r <= haddr;
      // read data captured at the address phase, shown in the data phase
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alt_r <= alternate_mode_control_rst;
    else
      alt_r <= alt_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fsel_r <= function_select_rst;
    else
      fsel_r <= fsel_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irda_r <= irda_control_rst;
    else
      irda_r <= irda_nxt;
  end

  // -------------------------------------------------------------------
  // bus answer: zero wait states, always okay
  // -------------------------------------------------------------------
  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // -------------------------------------------------------------------
  // line controls
  // -------------------------------------------------------------------
  wire [3:0] rs485_raw = {alt_r[addr_detect_bit], alt_r[auto_dir_bit],
    alt_r[auto_addr_bit], alt_r[multidrop_bit]};
  wire [3:0] rs485_nxt;
  wire lin_rx_nxt = is_lin && alt_r[lin_rx_bit];
  wire irda_tx_nxt = is_irda && irda_r[irda_tx_sel_bit];
  wire irda_rx_nxt = is_irda && !irda_r[irda_tx_sel_bit];

  // the four rs-485 enables are dropped unless rs-485 is the personality; rs485_addr_match is not gated
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_rs485
      assign rs485_nxt[g] = is_rs485 && rs485_raw[g];
    end
  endgenerate

  // -------------------------------------------------------------------
  // output registers: the line sees a setting one cycle after it lands
  // -------------------------------------------------------------------
  personality_t pers_out_r;
  logic [7:0] match_out_r;
  logic [3:0] rs485_out_r;
  logic lin_rx_out_r;
  logic irda_tx_out_r;
  logic irda_rx_out_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pers_out_r <= personality_t'(function_select_rst[1:0]);
      match_out_r <= alternate_mode_control_rst[addr_match_lsb +: 8];
      rs485_out_r <= 4'h0;
      lin_rx_out_r <= 1'b0;
      irda_tx_out_r <= 1'b0;
      irda_rx_out_r <= 1'b0;
    end
    else
    begin
      pers_out_r <= pers;
      match_out_r <= alt_r[addr_match_lsb +: 8];
      rs485_out_r <= rs485_nxt;
      lin_rx_out_r <= lin_rx_nxt;
      irda_tx_out_r <= irda_tx_nxt;
      irda_rx_out_r <= irda_rx_nxt;
    end
  end

  assign port_personality = pers_out_r;
  assign rs485_addr_match = match_out_r;
  assign rs485_addr_detect_on = rs485_out_r[3];
  assign rs485_auto_direction = rs485_out_r[2];
  // both modes set together is a software fault; passed through unchanged
  assign rs485_auto_addr_detect = rs485_out_r[1];
  assign rs485_normal_multidrop = rs485_out_r[0];
  assign lin_rx_enable = lin_rx_out_r;
  assign lin_break_active = brk_busy;
  assign irda_tx_enable = irda_tx_out_r;
  assign irda_rx_enable = irda_rx_out_r;
endmodule // uart_alt_function_control

/* logic/alt_func_pkg.sv */
// constants shared by the alternate function control block
package alt_func_pkg;
  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [7:0] irda_control_off = 8'h28;
  localparam logic [7:0] alternate_mode_control_off = 8'h2c;
  localparam logic [7:0] function_select_off = 8'h30;
  localparam logic [31:0] alternate_mode_control_rst = 32'h0000_0000;
  localparam logic [31:0] function_select_rst = 32'h0000_0000;
  localparam logic [31:0] irda_control_rst = 32'h0000_0000;
  localparam logic [31:0] alt_wr_mask = 32'hff00_87cf;
  localparam logic [31:0] fsel_wr_mask = 32'h0000_0003;
  localparam logic [31:0] irda_wr_mask = 32'h0000_0002;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int addr_match_lsb = 24;
  localparam int addr_detect_bit = 15;
  localparam int auto_dir_bit = 10;
  localparam int auto_addr_bit = 9;
  localparam int multidrop_bit = 8;
  localparam int lin_tx_bit = 7;
  localparam int lin_rx_bit = 6;
  localparam int break_len_lsb = 0;
  localparam int irda_tx_sel_bit = 1;
  // -------------------------------------------------------------------
  // break length offset in bit times
  // -------------------------------------------------------------------
  localparam logic [4:0] break_len_extra = 5'h02;
  // -------------------------------------------------------------------
  // port personality codes
  // -------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    pers_uart = 2'h0,
    pers_lin = 2'h1,
    pers_irda = 2'h2,
    pers_rs485 = 2'h3
  } personality_t;
endpackage

/* logic/lin_break_timer.sv */
// counts bit times of a lin break field
`timescale 1ns/100ps
module lin_break_timer
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic start,
  input wire logic bit_tick,
  input wire logic [3:0] break_length,
  // status
  output logic busy,
  output logic done
);
  import alt_func_pkg::*;

  typedef enum logic {st_idle, st_run} brk_state_t;

  brk_state_t state_r;
  logic [4:0] count_r;
  logic [4:0] target_r;
  logic done_r;
  wire last_tick = (state_r == st_run) && bit_tick && (count_r == target_r - 5'h01);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= st_idle;
      count_r <= 5'h00;
      target_r <= 5'h00;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= last_tick;
      case (state_r)
        st_idle:
        begin
          count_r <= 5'h00;
          if (start)
          begin
            // length latched so a mid-break write cannot stretch it
            target_r <= {1'b0, break_length} + break_len_extra;
            state_r <= st_run;
          end
        end
        st_run:
        begin
          if (last_tick)
            state_r <= st_idle;
          else if (bit_tick)
            count_r <= count_r + 5'h01;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  assign busy = (state_r == st_run);
  assign done = done_r;
endmodule // lin_break_timer

/* bench/line_side.sv */
// bit-time strobe source standing in for the line side timing
`timescale 1ns/100ps
module line_side
#(parameter int period = 3)
(
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // strobe
  output logic bit_tick
);
  logic [7:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_r <= 8'h00;
    else
      cnt_r <= (cnt_r == 8'(period - 1)) ? 8'h00 : cnt_r + 8'h01;
  // held low in reset so no tick can start a count early
  assign bit_tick = hresetn && cnt_r == 8'(period - 1);
endmodule // line_side

/* bench/alt_func_asserts.sv */
// port assertions for the alternate function control block
`timescale 1ns/100ps
module alt_func_asserts
(
  // bus
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [7:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic bit_tick,
  // modes
  input alt_func_pkg::personality_t port_personality,
  input logic [7:0] rs485_addr_match,
  input logic rs485_addr_detect_on,
  input logic rs485_auto_direction,
  input logic rs485_auto_addr_detect,
  input logic rs485_normal_multidrop,
  input logic lin_rx_enable,
  input logic lin_break_active,
  input logic irda_tx_enable,
  input logic irda_rx_enable
);
  import alt_func_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wf_r, wa_r;
  logic [4:0] tk_r;
  wire wr = hsel && htrans[1] && hready && hwrite;
  // ticks seen while the break runs
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {wf_r, wa_r, tk_r} <= '0;
    else
      {wf_r, wa_r, tk_r} <= {wr && haddr == function_select_off,
        wr && haddr == alternate_mode_control_off,
        lin_break_active ? tk_r + 5'(bit_tick) : 5'h00};
  property p_fsel; wf_r |=> ##1 port_personality == $past(hwdata[1:0], 2); endproperty
  a_fsel: assert property (p_fsel) else $error("personality");
  property p_match; wa_r |=> ##1 rs485_addr_match == $past(hwdata[31:24], 2); endproperty
  a_match: assert property (p_match) else $error("match value");
  property p_hold; $changed(rs485_addr_match) |-> $past(wa_r, 2); endproperty
  a_hold: assert property (p_hold) else $error("match changed");
  property p_gate; port_personality != pers_rs485 |-> !(rs485_addr_detect_on ||
    rs485_auto_direction || rs485_auto_addr_detect || rs485_normal_multidrop); endproperty
  a_gate: assert property (p_gate) else $error("rs485 gate");
  property p_lin; lin_rx_enable |-> port_personality == pers_lin; endproperty
  a_lin: assert property (p_lin) else $error("lin rx gate");
  property p_irda; port_personality == pers_irda ? irda_tx_enable != irda_rx_enable
    : !(irda_tx_enable || irda_rx_enable); endproperty
  a_irda: assert property (p_irda) else $error("irda dir");
  property p_bstart; $rose(lin_break_active) |-> port_personality == pers_lin; endproperty
  a_bstart: assert property (p_bstart) else $error("break start");
  property p_bend; $fell(lin_break_active) |-> $past(bit_tick) &&
    tk_r inside {[5'h02:5'h11]}; endproperty
  a_bend: assert property (p_bend) else $error("break length");
endmodule // alt_func_asserts
bind uart_alt_function_control alt_func_asserts chk_i (.*);

/* bench/testbench.sv */
// self-checking bench for the alternate function control block
`timescale 1ns/100ps
module testbench;
  import alt_func_pkg::*;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, bit_tick, hreadyout, hresp, t;
  logic [7:0] haddr = '0, rs485_addr_match;
  logic [1:0] htrans = '0, p;
  logic [31:0] hwdata = '0, hrdata, q, a;
  logic rs485_addr_detect_on, rs485_auto_direction, rs485_auto_addr_detect;
  logic rs485_normal_multidrop, lin_rx_enable, lin_break_active, irda_tx_enable, irda_rx_enable;
  personality_t port_personality;
  int err_total = 0, tests_run = 0, cyc = 0, n;
  logic [7:0] offs [3] = '{irda_control_off, alternate_mode_control_off, function_select_off};
  wire [16:0] outs = {rs485_addr_match, rs485_addr_detect_on, rs485_auto_direction,
    rs485_auto_addr_detect, rs485_normal_multidrop, lin_rx_enable, irda_tx_enable,
    irda_rx_enable, port_personality};
  always #5 hclk = ~hclk;
  line_side ls (.*);
  uart_alt_function_control uut (.hsize(3'h2), .hready(hreadyout), .*);
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
      results('1);
  end
  function automatic logic [16:0] ex(logic [31:0] v, logic [1:0] s, logic x);
    logic r;
    r = s == 2'h3;
    return {v[31:24], v[15] & r, v[10] & r, v[9] & r, v[8] & r, v[6] & (s == 2'h1),
      x & (s == 2'h2), !x & (s == 2'h2), s};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d);
    @(posedge hclk);
    {hsel, haddr, hwrite, htrans} <= {1'b1, ad, w, 2'h2};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rst();
    hresetn <= '0;
    repeat (16) @(posedge hclk);
    hresetn <= '1;
    foreach (offs[i])
    begin
      xfer(offs[i], '0, '0);
      chk(q, '0);
    end
    chk(32'(outs), '0);
  endtask
  task automatic results(input logic to);
    if (to)
      err_total++;
    $display("tests %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(85825));
    rst();
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      a = $urandom() & alt_wr_mask & ~32'h80;
      // software never asks for both rs-485 address modes
      a[9] = a[9] & ~a[8];
      p = i < 4 ? 2'(i) : 2'($urandom());
      t = 1'($urandom());
      xfer(alternate_mode_control_off, '1, a | 32'h00ff_7830);
      xfer(function_select_off, '1, {30'h3fff_ffff, p});
      xfer(irda_control_off, '1, {30'h3fff_ffff, t, 1'b1}); // fixed divider only
      xfer(alternate_mode_control_off, '0, '0);
      chk(q, a);
      xfer(function_select_off, '0, '0);
      chk(q, 32'(p));
      chk(32'(outs), 32'(ex(a, p, t)));
    end
    xfer(8'h34, '1, '1);
    xfer(8'h34, '0, '0);
    chk(q, '0);
    chk(32'({hresp, hreadyout}), 32'h1);
    $display("register test done");
    for (int k = 0; k < 3; k++)
    begin
      a = 32'h80 | (k == 0 ? 32'h0 : k == 1 ? 32'hf : 32'($urandom() & 15));
      xfer(function_select_off, '1, '0);
      xfer(alternate_mode_control_off, '1, a);
      xfer(alternate_mode_control_off, '0, '0);
      chk(q, a);
      chk(32'(lin_break_active), '0);
      xfer(function_select_off, '1, 32'h1);
      n = 0;
      repeat (150) @(posedge hclk) n += lin_break_active && bit_tick;
      chk(n, 32'(a[3:0]) + 32'h2);
      xfer(alternate_mode_control_off, '0, '0);
      chk(q, a & ~32'h80);
    end
    // a pending break withdrawn by a written zero never starts
    xfer(function_select_off, '1, '0);
    xfer(alternate_mode_control_off, '1, 32'h8f);
    xfer(alternate_mode_control_off, '1, 32'h0f);
    xfer(function_select_off, '1, 32'h1);
    xfer(alternate_mode_control_off, '0, '0);
    chk(q, 32'h0f);
    chk(32'(lin_break_active), '0);
    $display("break test done");
    rst();
    $display("second reset test done");
    results('0);
  end
endmodule // testbench
